/* hdl/duh_pkg.sv */
// Purpose: Shared constants and types for the dual UART host bus port controller
// Assumes: 10 MHz system clock, synchronous active-high reset
// Notes:   Bus phase lengths are counted in system clock cycles
package duh_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;

  // Bus phase times in ns
  localparam int unsigned T_SETUP_NS  = 100;
  localparam int unsigned T_STROBE_NS = 300;
  localparam int unsigned T_HOLD_NS   = 100;

  // Least times round up to whole cycles, never below one
  localparam int unsigned T_SETUP_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_HOLD_CYC   = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 4;

  // Modem control register position and its drive-mode bit
  localparam logic [2:0] MODEM_CTRL_ADDR = 3'h4;
  localparam int unsigned MCR_IRQ_EN_BIT = 3;

  // Values after reset
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] ADDR_RST = 3'h0;

  typedef enum logic
  {
    DUH_CHAN_A,
    DUH_CHAN_B
  } duh_chan_e;

endpackage : duh_pkg

/* hdl/duh_timer_if.sv */
// Purpose: Carrier between bus sequencer and its phase timer
// Assumes: One clock domain
// Notes:   load starts a count of len cycles; done pulses at its end
interface duh_timer_if;
  logic                       load;
  logic [duh_pkg::CNT_W-1:0]  len;
  logic                       done;

  modport master (output load, output len, input done);
  modport timer  (input load, input len, output done);
endinterface : duh_timer_if

/* hdl/duh_phase_timer.sv */
// Purpose: Counts one bus phase and pulses done at its end
// Assumes: len is at least one
// Notes:   A new load restarts the count
module duh_phase_timer
  import duh_pkg::*;
(
  // Clock and reset
  input  wire logic   clk_sys_i,
  input  wire logic   srst_i,
  // Control
  duh_timer_if.timer  tmr
);

  logic [CNT_W-1:0] count;
  logic             running;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      count   <= '0;
      running <= 1'b0;
      tmr.done <= 1'b0;
    end
    else
    begin
      tmr.done <= 1'b0;
      if (tmr.load)
      begin
        count   <= tmr.len - CNT_W'(1);
        running <= 1'b1;
      end
      else if (running)
      begin
        if (count == '0)
        begin
          running  <= 1'b0;
          tmr.done <= 1'b1;
        end
        else
        begin
          count <= count - CNT_W'(1);
        end
      end
    end
  end

endmodule : duh_phase_timer

/* hdl/duh_host_port.sv */
// Purpose: Host-side controller that runs register reads and writes on a dual UART parallel port
// Assumes: Device pins are asynchronous; inputs from the device pass two flip-flops
// Notes:   One request at a time; the interrupt pins are watched as three-state lines, trusted only while out2 is low
module duh_host_port
  import duh_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // User request
  input  wire logic        req_valid_i,
  input  wire logic        req_write_i,
  input  wire duh_pkg::duh_chan_e req_chan_i,
  input  wire logic [2:0]  req_addr_i,
  input  wire logic [7:0]  req_wdata_i,
  output logic             req_ready_o,
  output logic             rsp_valid_o,
  output logic [7:0]       rsp_rdata_o,
  // Device bus pins
  output logic [2:0]       addr_o,
  input  wire logic [7:0]  data_i,
  output logic [7:0]       data_o,
  output logic             data_oe_n_o,
  output logic             read_strobe_n_o,
  output logic             write_strobe_n_o,
  output logic             chan_a_select_n_o,
  output logic             chan_b_select_n_o,
  // Device status pins
  input  wire logic        chan_a_irq_i,
  input  wire logic        chan_b_irq_i,
  input  wire logic        chan_a_gp_out2_n_i,
  input  wire logic        chan_b_gp_out2_n_i,
  input  wire logic        chan_a_tx_ready_n_i,
  input  wire logic        chan_a_rx_ready_n_i,
  input  wire logic        chan_b_tx_ready_n_i,
  // Synchronised status to user
  output logic             chan_a_irq_o,
  output logic             chan_b_irq_o,
  output logic             chan_a_irq_mode_o,
  output logic             chan_b_irq_mode_o,
  output logic             chan_a_tx_ready_o,
  output logic             chan_a_rx_ready_o,
  output logic             chan_b_tx_ready_o
);

// How it works
// - Drive three-bit register address each transaction
// - Host samples read byte at strobe rise
// - Hold write data until write strobe rises
// - Channel A reached only with its select low
// - Channel B reached only with its select low
// - Never treat out2 as plain output

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } duh_state_e;

  duh_state_e  state;
  logic        is_write;
  logic [7:0]  data_in_s1;
  logic [7:0]  data_in_s2;
  logic [6:0]  stat_s1;
  logic [6:0]  stat_s2;

  duh_timer_if tmr ();

  duh_phase_timer u_timer
  (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .tmr       (tmr)
  );

  // Sequencer: setup, strobe low, hold with strobes high
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (req_valid_i)
          begin
            state <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          if (tmr.done)
          begin
            state <= ST_STROBE;
          end
        end
        ST_STROBE:
        begin
          if (tmr.done)
          begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (tmr.done)
          begin
            state <= ST_IDLE;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    tmr.load = 1'b0;
    tmr.len  = CNT_W'(T_SETUP_CYC);
    if (state == ST_IDLE && req_valid_i)
    begin
      tmr.load = 1'b1;
    end
    else if (state == ST_SETUP && tmr.done)
    begin
      tmr.load = 1'b1;
      tmr.len  = CNT_W'(T_STROBE_CYC);
    end
    else if (state == ST_STROBE && tmr.done)
    begin
      tmr.load = 1'b1;
      tmr.len  = CNT_W'(T_HOLD_CYC);
    end
  end

  // Address, select and write data held for the whole transaction
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      addr_o            <= ADDR_RST;
      data_o            <= DATA_RST;
      is_write          <= 1'b0;
      chan_a_select_n_o <= 1'b1;
      chan_b_select_n_o <= 1'b1;
    end
    else if (state == ST_IDLE && req_valid_i)
    begin
      addr_o            <= req_addr_i;
      data_o            <= req_wdata_i;
      is_write          <= req_write_i;
      chan_a_select_n_o <= (req_chan_i != DUH_CHAN_A);
      chan_b_select_n_o <= (req_chan_i != DUH_CHAN_B);
    end
    else if (state == ST_HOLD && tmr.done)
    begin
      chan_a_select_n_o <= 1'b1;
      chan_b_select_n_o <= 1'b1;
    end
  end

  // Strobes; only one of them can ever be low
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      read_strobe_n_o  <= 1'b1;
      write_strobe_n_o <= 1'b1;
    end
    else if (state == ST_SETUP && tmr.done)
    begin
      read_strobe_n_o  <= is_write;
      write_strobe_n_o <= !is_write;
    end
    else if (state == ST_STROBE && tmr.done)
    begin
      read_strobe_n_o  <= 1'b1;
      write_strobe_n_o <= 1'b1;
    end
  end

  // Host drives data from setup through hold of a write only
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      data_oe_n_o <= 1'b1;
    end
    else if (state == ST_IDLE && req_valid_i)
    begin
      data_oe_n_o <= !req_write_i;
    end
    else if (state == ST_HOLD && tmr.done)
    begin
      data_oe_n_o <= 1'b1;
    end
  end

  // Two-flop sync of device pins; the second stage is the only reader of the first
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      data_in_s1 <= DATA_RST;
      data_in_s2 <= DATA_RST;
      stat_s1    <= 7'h7e;
      stat_s2    <= 7'h7e;
    end
    else
    begin
      data_in_s1 <= data_i;
      data_in_s2 <= data_in_s1;
      stat_s1    <= {chan_b_tx_ready_n_i, chan_a_rx_ready_n_i, chan_a_tx_ready_n_i,
                     chan_b_gp_out2_n_i, chan_a_gp_out2_n_i, chan_b_irq_i, chan_a_irq_i};
      stat_s2    <= stat_s1;
    end
  end

  // Read byte is taken as the strobe rises; the sync delay is covered by the strobe width
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      rsp_rdata_o <= DATA_RST;
    end
    else if (state == ST_STROBE && tmr.done && !is_write)
    begin
      rsp_rdata_o <= data_in_s2;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      rsp_valid_o <= 1'b0;
      req_ready_o <= 1'b0;
    end
    else
    begin
      rsp_valid_o <= (state == ST_HOLD) && tmr.done;
      req_ready_o <= (state == ST_IDLE) && !req_valid_i
                     || (state == ST_HOLD) && tmr.done;
    end
  end

  // Interrupt mode is seen on out2: low means the interrupt pin is driven.
  // Out2 is only read here, never reused as a plain output.
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      chan_a_irq_o      <= 1'b0;
      chan_b_irq_o      <= 1'b0;
      chan_a_irq_mode_o <= 1'b0;
      chan_b_irq_mode_o <= 1'b0;
      chan_a_tx_ready_o <= 1'b0;
      chan_a_rx_ready_o <= 1'b0;
      chan_b_tx_ready_o <= 1'b0;
    end
    else
    begin
      chan_a_irq_mode_o <= !stat_s2[2];
      chan_b_irq_mode_o <= !stat_s2[3];
      chan_a_irq_o      <= !stat_s2[2] && stat_s2[0];
      chan_b_irq_o      <= !stat_s2[3] && stat_s2[1];
      chan_a_tx_ready_o <= !stat_s2[4];
      chan_a_rx_ready_o <= !stat_s2[5];
      chan_b_tx_ready_o <= !stat_s2[6];
    end
  end

  AST_ONE_SELECT: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !(!chan_a_select_n_o && !chan_b_select_n_o))
    else $error("both channel selects low");

  AST_STROBES_EXCL: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !(!read_strobe_n_o && !write_strobe_n_o))
    else $error("both strobes low");

  AST_STROBE_NEEDS_SELECT: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (!read_strobe_n_o || !write_strobe_n_o) |-> (!chan_a_select_n_o || !chan_b_select_n_o))
    else $error("strobe without a select");

  AST_READ_NO_DRIVE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !read_strobe_n_o |-> data_oe_n_o)
    else $error("host drives bus during read");

  AST_WRITE_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $rose(write_strobe_n_o) |-> !data_oe_n_o && $stable(data_o))
    else $error("write data gone at strobe rise");

  // Strobe stands one cycle longer than its count, as the sequencer acts on the registered done
  AST_STROBE_WIDTH: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $fell(read_strobe_n_o) |-> !read_strobe_n_o [*4] ##1 read_strobe_n_o)
    else $error("read strobe width wrong");

  AST_ADDR_STABLE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (!read_strobe_n_o || !write_strobe_n_o) |-> $stable(addr_o))
    else $error("address moved under strobe");

  AST_WRITE_START: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $fell(write_strobe_n_o) |-> $past(state) == ST_SETUP && is_write)
    else $error("write strobe without write request");

  AST_READ_RSP: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $rose(read_strobe_n_o) |-> ##[1:2] rsp_valid_o)
    else $error("read answer late");

  // Mode output trails the out2 pin by the two sync stages and its own register
  AST_IRQ_MODE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    chan_a_irq_mode_o == !$past(chan_a_gp_out2_n_i, 3))
    else $error("irq mode does not follow out2");

  COV_READ_A: cover property (@(posedge clk_sys_i) !read_strobe_n_o && !chan_a_select_n_o);
  COV_WRITE_B: cover property (@(posedge clk_sys_i) !write_strobe_n_o && !chan_b_select_n_o);
  COV_IRQ_A: cover property (@(posedge clk_sys_i) chan_a_irq_o);

endmodule : duh_host_port

/* dv/duh_uart_model.sv */
// Purpose: Behavioural two-channel UART register port for the host controller bench
// Assumes: Strobes and selects are asynchronous; only edges and levels matter
// Notes:   Register file is generic; reading back returns the last written byte
module duh_uart_model
(
  // Control
  input  wire logic       rst_i,
  input  wire logic [1:0] irq_req_i,
  input  wire logic       rx_avail_i,
  input  wire logic       host_oe_n_i,
  // Host bus
  input  wire logic [2:0] addr_i,
  inout  wire logic [7:0] data_io,
  input  wire logic       read_strobe_n_i,
  input  wire logic       write_strobe_n_i,
  input  wire logic       chan_a_select_n_i,
  input  wire logic       chan_b_select_n_i,
  // Status pins
  output wire logic       chan_a_irq_o,
  output wire logic       chan_b_irq_o,
  output logic            chan_a_gp_out2_n_o,
  output logic            chan_b_gp_out2_n_o,
  output logic            chan_a_tx_ready_n_o,
  output logic            chan_a_rx_ready_n_o,
  output logic            chan_b_tx_ready_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] regs [2][8];
  logic [7:0] rdata;
  logic [7:0] last;
  logic [1:0] tx_full;
  logic       sel;
  logic       chb;
  logic       rd_on;

  assign sel   = !chan_a_select_n_i || !chan_b_select_n_i;
  assign chb   = !chan_b_select_n_i;
  assign rd_on = !read_strobe_n_i && sel;
  // A released bus never keeps a stale copy of the last byte
  assign data_io = rd_on ? rdata : (host_oe_n_i ? ~last : 8'hzz);

  always @(negedge read_strobe_n_i)
    if (sel)
    begin
      rdata = regs[chb][addr_i];
      last  = rdata;
    end

  always @(posedge write_strobe_n_i)
    if (sel)
    begin
      regs[chb][addr_i] = data_io;
      last = data_io;
      if (addr_i == 3'h0)
        tx_full[chb] = 1'b1;
    end

  // Level-sensitive, so a reset that is already high at time zero is not missed
  always
  begin
    wait (rst_i === 1'b1);
    for (int c = 0; c < 2; c++)
      for (int a = 0; a < 8; a++)
        regs[c][a] = 8'h00;
    tx_full = 2'h0;
    last    = 8'h00;
    wait (rst_i !== 1'b1);
  end

  assign chan_a_irq_o        = regs[0][4][3] ? irq_req_i[0] : 1'bz;
  assign chan_b_irq_o        = regs[1][4][3] ? irq_req_i[1] : 1'bz;
  assign chan_a_gp_out2_n_o  = ~regs[0][4][3];
  assign chan_b_gp_out2_n_o  = ~regs[1][4][3];
  assign chan_a_tx_ready_n_o = tx_full[0];
  assign chan_b_tx_ready_n_o = tx_full[1];
  assign chan_a_rx_ready_n_o = ~rx_avail_i;
endmodule : duh_uart_model

/* dv/tb.sv */
// Purpose: Self-checking bench for the dual UART host port controller
// Assumes: Outputs are sampled at the falling edge, inputs driven at the rising edge
// Notes:   Interrupt pins are pulled down so a floating pin reads low
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import duh_pkg::*;
  // Each phase lasts its count plus one cycle: the sequencer acts on the timer's registered done
  localparam int RSP_LAT = T_SETUP_CYC + T_STROBE_CYC + T_HOLD_CYC + 3;
  logic       clk_sys_i, srst_i, req_valid_i, req_write_i;
  duh_chan_e  req_chan_i;
  logic [2:0] req_addr_i, addr_o;
  logic [7:0] req_wdata_i, rsp_rdata_o, data_o, rd;
  logic       req_ready_o, rsp_valid_o, data_oe_n_o, read_strobe_n_o, write_strobe_n_o;
  logic       chan_a_select_n_o, chan_b_select_n_o, chan_a_gp_out2_n_i, chan_b_gp_out2_n_i;
  logic       chan_a_tx_ready_n_i, chan_a_rx_ready_n_i, chan_b_tx_ready_n_i;
  logic       chan_a_irq_o, chan_b_irq_o, chan_a_irq_mode_o, chan_b_irq_mode_o;
  logic       chan_a_tx_ready_o, chan_a_rx_ready_o, chan_b_tx_ready_o, rx_avail;
  logic [1:0] irq_req;
  wire  [7:0] data_i;
  tri0        chan_a_irq_i, chan_b_irq_i;
  int         fail_count, samples_checked;

  assign data_i = data_oe_n_o ? 8'hzz : data_o;

  duh_host_port duh_host_port_inst (.clk_sys_i, .srst_i, .req_valid_i, .req_write_i, .req_chan_i,
    .req_addr_i, .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .addr_o, .data_i, .data_o,
    .data_oe_n_o, .read_strobe_n_o, .write_strobe_n_o, .chan_a_select_n_o, .chan_b_select_n_o,
    .chan_a_irq_i, .chan_b_irq_i, .chan_a_gp_out2_n_i, .chan_b_gp_out2_n_i, .chan_a_tx_ready_n_i,
    .chan_a_rx_ready_n_i, .chan_b_tx_ready_n_i, .chan_a_irq_o, .chan_b_irq_o, .chan_a_irq_mode_o,
    .chan_b_irq_mode_o, .chan_a_tx_ready_o, .chan_a_rx_ready_o, .chan_b_tx_ready_o);

  duh_uart_model duh_uart_model_inst (.rst_i(srst_i), .irq_req_i(irq_req), .rx_avail_i(rx_avail),
    .host_oe_n_i(data_oe_n_o), .addr_i(addr_o), .data_io(data_i), .read_strobe_n_i(read_strobe_n_o),
    .write_strobe_n_i(write_strobe_n_o), .chan_a_select_n_i(chan_a_select_n_o),
    .chan_b_select_n_i(chan_b_select_n_o), .chan_a_irq_o(chan_a_irq_i), .chan_b_irq_o(chan_b_irq_i),
    .chan_a_gp_out2_n_o(chan_a_gp_out2_n_i), .chan_b_gp_out2_n_o(chan_b_gp_out2_n_i),
    .chan_a_tx_ready_n_o(chan_a_tx_ready_n_i), .chan_a_rx_ready_n_o(chan_a_rx_ready_n_i),
    .chan_b_tx_ready_n_o(chan_b_tx_ready_n_i));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic final_report;
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : settle

  // One transfer; watches strobe length, select, direction and answer time on the way
  task automatic bus(input logic wr, input duh_chan_e ch, input logic [2:0] a, input logic [7:0] wd);
    int n;
    int lo;
    n  = 0;
    lo = 0;
    @(negedge clk_sys_i);
    while (req_ready_o !== 1'b1 && n < 50)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_chan_i  <= ch;
    req_addr_i  <= a;
    req_wdata_i <= wd;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk_sys_i);
      n++;
      chk("idle_strobe", 8'h01, {7'h0, wr ? read_strobe_n_o : write_strobe_n_o});
      if ((wr ? write_strobe_n_o : read_strobe_n_o) === 1'b0)
      begin
        lo++;
        chk("selects", (ch == DUH_CHAN_A) ? 8'h02 : 8'h01, {6'h0, chan_b_select_n_o, chan_a_select_n_o});
        chk("addr", {5'h0, a}, {5'h0, addr_o});
        chk("data_oe_n", {7'h0, ~wr}, {7'h0, data_oe_n_o});
      end
    end
    while (rsp_valid_o !== 1'b1 && n < 20);
    chk("latency", 8'(RSP_LAT + 1), n[7:0]);
    chk("strobe_len", 8'(T_STROBE_CYC + 1), lo[7:0]);
    rd = rsp_rdata_o;
  endtask : bus

  task automatic t_reset;
    chk("rst_pins", 8'h1f, {3'h0, read_strobe_n_o, write_strobe_n_o, chan_a_select_n_o,
      chan_b_select_n_o, data_oe_n_o});
    chk("rst_ready", 8'h00, {7'h0, req_ready_o});
    @(posedge clk_sys_i);
    srst_i <= 1'b0;
    settle(6);
    chk("ready_after", 8'h01, {7'h0, req_ready_o});
    chk("tx_ready_rst", 8'h03, {6'h0, chan_a_tx_ready_o, chan_b_tx_ready_o});
    chk("mode_rst", 8'h00, {6'h0, chan_a_irq_mode_o, chan_b_irq_mode_o});
  endtask : t_reset

  // Same address on both channels back to back; each must keep its own byte
  task automatic t_rw;
    for (int a = 0; a < 8; a++)
      if (a != 4)
      begin
        bus(1'b1, DUH_CHAN_A, a[2:0], 8'h30 + 8'(a));
        bus(1'b1, DUH_CHAN_B, a[2:0], 8'hc5 - 8'(a));
        bus(1'b0, DUH_CHAN_A, a[2:0], 8'h00);
        chk("rd_a", 8'h30 + 8'(a), rd);
        bus(1'b0, DUH_CHAN_B, a[2:0], 8'h00);
        chk("rd_b", 8'hc5 - 8'(a), rd);
      end
    settle(6);
    chk("tx_ready_full", 8'h00, {6'h0, chan_a_tx_ready_o, chan_b_tx_ready_o});
  endtask : t_rw

  task automatic t_mode;
    for (int c = 0; c < 2; c++)
    begin
      bus(1'b1, duh_chan_e'(c), 3'h4, 8'h08);
      settle(6);
      chk("mode_on", 8'h01, {7'h0, c ? chan_b_irq_mode_o : chan_a_irq_mode_o});
      @(posedge clk_sys_i);
      irq_req[c] <= 1'b1;
      settle(6);
      chk("irq_on", 8'h01, {7'h0, c ? chan_b_irq_o : chan_a_irq_o});
      bus(1'b0, duh_chan_e'(c), 3'h4, 8'h00);
      chk("mcr_rd", 8'h08, rd);
      bus(1'b1, duh_chan_e'(c), 3'h4, 8'h00);
      settle(6);
      chk("mode_off", 8'h00, {7'h0, c ? chan_b_irq_mode_o : chan_a_irq_mode_o});
      chk("irq_float", 8'h00, {7'h0, c ? chan_b_irq_o : chan_a_irq_o});
      @(posedge clk_sys_i);
      irq_req[c] <= 1'b0;
    end
  endtask : t_mode

  task automatic t_rx_ready;
    @(posedge clk_sys_i);
    rx_avail <= 1'b1;
    settle(6);
    chk("rx_ready_on", 8'h01, {7'h0, chan_a_rx_ready_o});
    @(posedge clk_sys_i);
    rx_avail <= 1'b0;
    settle(6);
    chk("rx_ready_off", 8'h00, {7'h0, chan_a_rx_ready_o});
  endtask : t_rx_ready

  initial
  begin
    srst_i      = 1'b1;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_chan_i  = DUH_CHAN_A;
    req_addr_i  = 3'h0;
    req_wdata_i = 8'h00;
    irq_req     = 2'h0;
    rx_avail    = 1'b0;
    fail_count  = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    t_reset();
    t_rw();
    t_mode();
    t_rx_ready();
    final_report();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    fail_count++;
    final_report();
  end
endmodule : tb
